/* logic/lv_reset_pkg.sv */
package lv_reset_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_SYS_HZ      = 125_000_000;
   localparam int unsigned SLOW_OSC_HZ     = 32_000;
   localparam int unsigned SLOW_DIV_CYCLES = CLK_SYS_HZ / SLOW_OSC_HZ;
   localparam int unsigned DIV_WIDTH       = 12;
   // No figure is known for the code fault delay; slow-oscillator ticks
   localparam int unsigned CODE_FAULT_DELAY_TICKS = 16;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register map, 8-bit data
   localparam int unsigned ADDR_WIDTH = 4;
   localparam int unsigned DATA_WIDTH = 8;
   localparam logic [3:0] ADDR_THRESHOLD_CODE = 4'h0;
   localparam logic [3:0] ADDR_FILTER_SELECT  = 4'h1;
   localparam logic [3:0] ADDR_RESET_CAUSE    = 4'h2;
   localparam logic [3:0] ADDR_RESET_STATUS   = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK       = 4'h5;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values and valid codes
   localparam logic [7:0] THRESHOLD_CODE_RESET = 8'h55;
   localparam logic [7:0] THRESHOLD_CODE_A     = 8'h55;
   localparam logic [7:0] THRESHOLD_CODE_B     = 8'h33;
   localparam logic [7:0] THRESHOLD_CODE_C     = 8'h99;
   localparam logic [7:0] THRESHOLD_CODE_D     = 8'hAA;
   localparam logic [1:0] FILTER_SELECT_RESET  = 2'h1;
   localparam logic [4:0] WDT_KEY_A            = 5'h0A;
   localparam logic [4:0] WDT_KEY_B            = 5'h15;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Qualify time, in slow ticks, per filter select
   localparam logic [7:0] QUALIFY_TICKS_0 = 8'h08;
   localparam logic [7:0] QUALIFY_TICKS_1 = 8'h20;
   localparam logic [7:0] QUALIFY_TICKS_2 = 8'h40;
   localparam logic [7:0] QUALIFY_TICKS_3 = 8'h80;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned CAUSE_LOWVOLT_BIT    = 2;
   localparam int unsigned CAUSE_CODE_FAULT_BIT = 1;
   localparam int unsigned CAUSE_KEY_FAULT_BIT  = 0;
   localparam int unsigned STATUS_TIMEOUT_BIT   = 0;
   localparam int unsigned STATUS_POWERDOWN_BIT = 1;
   localparam int unsigned IRQ_WIDTH            = 5;
   localparam int unsigned IRQ_LOWVOLT_BIT      = 0;
   localparam int unsigned IRQ_CODE_FAULT_BIT   = 1;
   localparam int unsigned IRQ_KEY_FAULT_BIT    = 2;
   localparam int unsigned IRQ_RUN_TIMEOUT_BIT  = 3;
   localparam int unsigned IRQ_LP_TIMEOUT_BIT   = 4;

   typedef enum logic [1:0] {
      MODE_FAST  = 2'h0,
      MODE_SLOW  = 2'h1,
      MODE_IDLE  = 2'h3,
      MODE_SLEEP = 2'h2
   } power_mode_t;

endpackage : lv_reset_pkg

/* logic/qualify_timer.sv */
`timescale 1ns/1ps

module qualify_timer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   input  wire logic             run_in,
   input  wire logic             tick_in,
   input  wire logic [WIDTH-1:0] limit_in,
   output logic                  done_out
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic             fired_q;
   logic             fired_d;
   logic             done_d;

   if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
      $error("qualify_timer: WIDTH out of range");
   end

   // Fires once per run; count never passes the limit, so no wrap
   always_comb begin
      count_d = count_q;
      fired_d = fired_q;
      done_d  = 1'b0;
      if (!run_in) begin
         count_d = '0;
         fired_d = 1'b0;
      end else begin
         if (tick_in && !fired_q && count_q < limit_in) begin
            count_d = count_q + 1'b1;
         end
         // Also catches a limit lowered below the running count
         done_d  = !fired_q && count_d >= limit_in;
         fired_d = fired_q | done_d;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_q  <= '0;
         fired_q  <= 1'b0;
         done_out <= 1'b0;
      end else begin
         count_q  <= count_d;
         fired_q  <= fired_d;
         done_out <= done_d;
      end
   end

endmodule : qualify_timer

/* logic/low_voltage_and_reset_flag_logic.sv */
`timescale 1ns/1ps

// Overview of operation
// - Low-voltage detection is off in SLEEP and IDLE and active in FAST and SLOW.
// - Only the four threshold codes 55h, 33h, 99h and AAh are valid, all one 3.15V level.
// - An invalid threshold code forces a full reset after the fixed delay and restores 55h.
// - A low-voltage reset needs the supply low beyond the qualify time and keeps the code.
// - Filter select 00/01/10/11 sets the qualify time to 7~8/31~32/63~64/127~128 periods.
// - Filter select bits 7..2 read zero; only bits 1..0 are stored.
// - The low-voltage cause flag, bit 2, sets on a qualified reset and clears by writing 0.
// - The code fault flag, bit 1, sets while the code is invalid and clears by writing 0.
// - Reset cause bits 7..3 read zero; only bits 2..0 hold flags.
// - A watchdog timeout in FAST or SLOW gives a full reset and sets the timeout flag.
// - A watchdog timeout in SLEEP or IDLE clears only PC and SP and sets the timeout flag.
// - Power-on clears timeout and power-down flags; low-voltage leaves them; SLEEP/IDLE timeouts set both, FAST/SLOW only timeout.
// - Power-on reset holds the core reset, which zeroes PC, SP, interrupts, timers and ports.
// - A watchdog key other than 01010b or 10101b resets after the delay and sets bit 0.
module low_voltage_and_reset_flag_logic #(
   parameter int unsigned SLOW_DIV_CYCLES        = lv_reset_pkg::SLOW_DIV_CYCLES,
   parameter int unsigned CODE_FAULT_DELAY_TICKS = lv_reset_pkg::CODE_FAULT_DELAY_TICKS
) (
   input  wire logic        clk_sys_in,
   input  wire logic        rstn_in,
   input  wire logic        supply_ok_in,
   input  wire logic [1:0]  power_mode_in,
   input  wire logic        wdt_timeout_in,
   input  wire logic [4:0]  wdt_key_field_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             core_reset_out,
   output logic             pc_sp_clear_out,
   output logic             wdt_restart_out,
   output logic             lv_detect_enable_out,
   output logic             irq_out
);

   if (SLOW_DIV_CYCLES < 2 || SLOW_DIV_CYCLES > (1 << lv_reset_pkg::DIV_WIDTH)) begin : g_div_chk
      $error("SLOW_DIV_CYCLES out of range");
   end
   if (CODE_FAULT_DELAY_TICKS < 1 || CODE_FAULT_DELAY_TICKS > 255) begin : g_dly_chk
      $error("CODE_FAULT_DELAY_TICKS out of range");
   end

   localparam logic [11:0] DIV_LAST  = 12'(SLOW_DIV_CYCLES - 1);
   localparam logic [7:0]  DLY_TICKS = 8'(CODE_FAULT_DELAY_TICKS);
   localparam int unsigned IW        = lv_reset_pkg::IRQ_WIDTH;

   function automatic logic code_is_valid(input logic [7:0] code);
      code_is_valid = (code == lv_reset_pkg::THRESHOLD_CODE_A) ||
                      (code == lv_reset_pkg::THRESHOLD_CODE_B) ||
                      (code == lv_reset_pkg::THRESHOLD_CODE_C) ||
                      (code == lv_reset_pkg::THRESHOLD_CODE_D);
   endfunction : code_is_valid

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Slow oscillator tick
   logic [11:0] div_q;
   logic [11:0] div_d;
   logic        tick_q;
   logic        tick_d;

   always_comb begin
      tick_d = (div_q == DIV_LAST);
      div_d  = tick_d ? 12'h000 : div_q + 12'h001;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_q  <= 12'h000;
         tick_q <= 1'b0;
      end else begin
         div_q  <= div_d;
         tick_q <= tick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Event sources
   logic [7:0] threshold_q;
   logic [1:0] filter_q;
   logic [7:0] lv_limit;
   logic       lv_lowpower;
   logic       lv_run;
   logic       code_run;
   logic       key_run;
   logic       lv_done;
   logic       code_done;
   logic       key_done;
   logic       wdt_run_to;
   logic       wdt_lp_to;
   logic       full_reset_req;

   always_comb begin
      lv_lowpower = (power_mode_in == lv_reset_pkg::MODE_IDLE) ||
                    (power_mode_in == lv_reset_pkg::MODE_SLEEP);
      lv_run      = !lv_lowpower && !supply_ok_in;
      code_run    = !code_is_valid(threshold_q);
      key_run     = (wdt_key_field_in != lv_reset_pkg::WDT_KEY_A) &&
                    (wdt_key_field_in != lv_reset_pkg::WDT_KEY_B);
      wdt_run_to  = wdt_timeout_in && !lv_lowpower;
      wdt_lp_to   = wdt_timeout_in && lv_lowpower;
      case (filter_q)
         2'h0:    lv_limit = lv_reset_pkg::QUALIFY_TICKS_0;
         2'h1:    lv_limit = lv_reset_pkg::QUALIFY_TICKS_1;
         2'h2:    lv_limit = lv_reset_pkg::QUALIFY_TICKS_2;
         2'h3:    lv_limit = lv_reset_pkg::QUALIFY_TICKS_3;
         default: lv_limit = lv_reset_pkg::QUALIFY_TICKS_3;
      endcase
      full_reset_req = lv_done || code_done || key_done || wdt_run_to;
   end

   qualify_timer #(.WIDTH(8)) u_lv_timer (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .run_in     (lv_run),
      .tick_in    (tick_q),
      .limit_in   (lv_limit),
      .done_out   (lv_done)
   );

   qualify_timer #(.WIDTH(8)) u_code_timer (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .run_in     (code_run),
      .tick_in    (tick_q),
      .limit_in   (DLY_TICKS),
      .done_out   (code_done)
   );

   qualify_timer #(.WIDTH(8)) u_key_timer (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .run_in     (key_run),
      .tick_in    (tick_q),
      .limit_in   (DLY_TICKS),
      .done_out   (key_done)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]    threshold_d;
   logic [1:0]    filter_d;
   logic [2:0]    cause_q;
   logic [2:0]    cause_d;
   logic [1:0]    status_q;
   logic [1:0]    status_d;
   logic [IW-1:0] irq_stat_q;
   logic [IW-1:0] irq_stat_d;
   logic [IW-1:0] irq_mask_q;
   logic [IW-1:0] irq_mask_d;
   logic [IW-1:0] irq_set;
   logic [7:0]    rdata_d;
   logic          irq_d;
   logic          wr_thr;
   logic          wr_cause;
   logic          wr_status;

   always_comb begin
      wr_thr    = reg_wr_in && reg_addr_in == lv_reset_pkg::ADDR_THRESHOLD_CODE;
      wr_cause  = reg_wr_in && reg_addr_in == lv_reset_pkg::ADDR_RESET_CAUSE;
      wr_status = reg_wr_in && reg_addr_in == lv_reset_pkg::ADDR_RESET_STATUS;

      // Restore beats a same-cycle write, else a bad code could survive
      threshold_d = threshold_q;
      if (code_done) begin
         threshold_d = lv_reset_pkg::THRESHOLD_CODE_RESET;
      end else if (wr_thr) begin
         threshold_d = reg_wdata_in;
      end

      filter_d = filter_q;
      if (reg_wr_in && reg_addr_in == lv_reset_pkg::ADDR_FILTER_SELECT) begin
         filter_d = reg_wdata_in[1:0];
      end

      // Software may only clear; hardware set wins
      cause_d = cause_q & ~(wr_cause ? ~reg_wdata_in[2:0] : 3'h0);
      cause_d[lv_reset_pkg::CAUSE_LOWVOLT_BIT]    |= lv_done;
      cause_d[lv_reset_pkg::CAUSE_CODE_FAULT_BIT] |= code_run;
      cause_d[lv_reset_pkg::CAUSE_KEY_FAULT_BIT]  |= key_run;

      // Low-voltage reset leaves both flags alone
      status_d = status_q & ~(wr_status ? ~reg_wdata_in[1:0] : 2'h0);
      status_d[lv_reset_pkg::STATUS_TIMEOUT_BIT]   |= wdt_timeout_in;
      status_d[lv_reset_pkg::STATUS_POWERDOWN_BIT] |= wdt_lp_to;

      irq_set = '0;
      irq_set[lv_reset_pkg::IRQ_LOWVOLT_BIT]     = lv_done;
      irq_set[lv_reset_pkg::IRQ_CODE_FAULT_BIT]  = code_done;
      irq_set[lv_reset_pkg::IRQ_KEY_FAULT_BIT]   = key_done;
      irq_set[lv_reset_pkg::IRQ_RUN_TIMEOUT_BIT] = wdt_run_to;
      irq_set[lv_reset_pkg::IRQ_LP_TIMEOUT_BIT]  = wdt_lp_to;
      irq_stat_d = irq_set |
                   (irq_stat_q & {IW{!(reg_rd_in &&
                                      reg_addr_in == lv_reset_pkg::ADDR_IRQ_STATUS)}});
      irq_mask_d = irq_mask_q;
      if (reg_wr_in && reg_addr_in == lv_reset_pkg::ADDR_IRQ_MASK) begin
         irq_mask_d = reg_wdata_in[IW-1:0];
      end
      irq_d = |(irq_stat_d & irq_mask_d);

      // Reads show the value before any read clear
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            lv_reset_pkg::ADDR_THRESHOLD_CODE: rdata_d = threshold_q;
            lv_reset_pkg::ADDR_FILTER_SELECT:  rdata_d = {6'h00, filter_q};
            lv_reset_pkg::ADDR_RESET_CAUSE:    rdata_d = {5'h00, cause_q};
            lv_reset_pkg::ADDR_RESET_STATUS:   rdata_d = {6'h00, status_q};
            lv_reset_pkg::ADDR_IRQ_STATUS:     rdata_d = {3'h0, irq_stat_q};
            lv_reset_pkg::ADDR_IRQ_MASK:       rdata_d = {3'h0, irq_mask_q};
            default:                           rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         threshold_q          <= lv_reset_pkg::THRESHOLD_CODE_RESET;
         filter_q             <= lv_reset_pkg::FILTER_SELECT_RESET;
         cause_q              <= 3'h0;
         status_q             <= 2'h0;
         irq_stat_q           <= '0;
         irq_mask_q           <= '0;
         reg_rdata_out        <= 8'h00;
         core_reset_out       <= 1'b1;
         pc_sp_clear_out      <= 1'b0;
         wdt_restart_out      <= 1'b1;
         lv_detect_enable_out <= 1'b0;
         irq_out              <= 1'b0;
      end else begin
         threshold_q          <= threshold_d;
         filter_q             <= filter_d;
         cause_q              <= cause_d;
         status_q             <= status_d;
         irq_stat_q           <= irq_stat_d;
         irq_mask_q           <= irq_mask_d;
         reg_rdata_out        <= rdata_d;
         core_reset_out       <= full_reset_req;
         pc_sp_clear_out      <= wdt_lp_to && !full_reset_req;
         wdt_restart_out      <= full_reset_req || wdt_lp_to;
         lv_detect_enable_out <= !lv_lowpower;
         irq_out              <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [19:0] low_cnt_q;
   logic [19:0] low_cnt_d;

   always_comb begin
      low_cnt_d = lv_run ? low_cnt_q + 20'h00001 : 20'h00000;
   end

   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_cnt_q <= 20'h00000;
      end else begin
         low_cnt_q <= low_cnt_d;
      end
   end

   a_lv_off_lowpower: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      lv_lowpower |=> !lv_done && !lv_detect_enable_out)
      else $error("low-voltage reset active in low-power mode");

   a_valid_code_quiet: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !code_run |=> !code_done)
      else $error("code fault reset with valid code");

   a_code_restore: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      code_done |=> threshold_q == lv_reset_pkg::THRESHOLD_CODE_RESET && core_reset_out)
      else $error("code fault did not restore threshold code");

   a_lv_keeps_code: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      lv_done && !code_done && !wr_thr |=> threshold_q == $past(threshold_q))
      else $error("low-voltage reset changed threshold code");

   a_lv_qualify_time: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      lv_done |-> low_cnt_q >=
         20'((32'(lv_limit) - 32'd1) * SLOW_DIV_CYCLES))
      else $error("low-voltage reset before qualify time");

   a_filter_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      reg_rd_in && reg_addr_in == lv_reset_pkg::ADDR_FILTER_SELECT
      |=> reg_rdata_out[7:2] == 6'h00)
      else $error("filter select upper bits not zero");

   a_lv_flag_set: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      lv_done |=> cause_q[lv_reset_pkg::CAUSE_LOWVOLT_BIT] ##1
                  cause_q[lv_reset_pkg::CAUSE_LOWVOLT_BIT] || $past(wr_cause))
      else $error("low-voltage cause flag lost");

   a_code_flag_set: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      code_run |=> cause_q[lv_reset_pkg::CAUSE_CODE_FAULT_BIT])
      else $error("code fault flag not set");

   a_cause_upper_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      reg_rd_in && reg_addr_in == lv_reset_pkg::ADDR_RESET_CAUSE
      |=> reg_rdata_out[7:3] == 5'h00)
      else $error("reset cause upper bits not zero");

   a_run_timeout: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      wdt_run_to |=> core_reset_out && status_q[lv_reset_pkg::STATUS_TIMEOUT_BIT])
      else $error("run-mode timeout without full reset");

   a_lp_timeout: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      wdt_lp_to && !full_reset_req |=> pc_sp_clear_out && !core_reset_out)
      else $error("low-power timeout did more than PC and SP clear");

   a_lp_flags: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      wdt_lp_to |=> status_q == 2'h3)
      else $error("low-power timeout flags wrong");

   a_key_fault: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      key_done |=> core_reset_out && cause_q[lv_reset_pkg::CAUSE_KEY_FAULT_BIT])
      else $error("key fault reset or flag missing");

   a_lv_restart: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
      !lv_run |=> !lv_done)
      else $error("qualify counter fired with supply high");

endmodule : low_voltage_and_reset_flag_logic

/* test/testbench.sv */
`timescale 1ns/1ps

module testbench;

   localparam logic [3:0] A_CODE = lv_reset_pkg::ADDR_THRESHOLD_CODE;
   localparam logic [3:0] A_FILT = lv_reset_pkg::ADDR_FILTER_SELECT;
   localparam logic [3:0] A_CAUS = lv_reset_pkg::ADDR_RESET_CAUSE;
   localparam logic [3:0] A_STAT = lv_reset_pkg::ADDR_RESET_STATUS;
   localparam logic [3:0] A_IRQS = lv_reset_pkg::ADDR_IRQ_STATUS;
   localparam logic [3:0] A_MASK = lv_reset_pkg::ADDR_IRQ_MASK;
   // Short slow tick keeps the 128-period qualify count cheap
   localparam int unsigned DIV    = 4;
   localparam int unsigned DLY    = 2;
   localparam logic [7:0]  CODES [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};

   logic        clk_sys_in       = 1'b0;
   logic        rstn_in          = 1'b0;
   logic        supply_ok_in     = 1'b1;
   logic [1:0]  power_mode_in    = 2'h0;
   logic        wdt_timeout_in   = 1'b0;
   logic [4:0]  wdt_key_field_in = 5'h0A;
   logic [3:0]  reg_addr_in      = 4'h0;
   logic [7:0]  reg_wdata_in     = 8'h00;
   logic        reg_wr_in        = 1'b0;
   logic        reg_rd_in        = 1'b0;
   logic [7:0]  reg_rdata_out;
   logic        core_reset_out;
   logic        pc_sp_clear_out;
   logic        wdt_restart_out;
   logic        lv_detect_enable_out;
   logic        irq_out;
   int          n_fail           = 0;
   int          checked          = 0;
   int          n_core           = 0;
   int          cyc              = 0;
   int          base             = 0;
   logic [31:0] seed             = 32'h0000D3BF;
   logic [7:0]  code_now         = 8'h55;

   low_voltage_and_reset_flag_logic #(
      .SLOW_DIV_CYCLES        (DIV),
      .CODE_FAULT_DELAY_TICKS (DLY)
   ) low_voltage_and_reset_flag_logic_inst (
      .clk_sys_in           (clk_sys_in),
      .rstn_in              (rstn_in),
      .supply_ok_in         (supply_ok_in),
      .power_mode_in        (power_mode_in),
      .wdt_timeout_in       (wdt_timeout_in),
      .wdt_key_field_in     (wdt_key_field_in),
      .reg_addr_in          (reg_addr_in),
      .reg_wdata_in         (reg_wdata_in),
      .reg_wr_in            (reg_wr_in),
      .reg_rd_in            (reg_rd_in),
      .reg_rdata_out        (reg_rdata_out),
      .core_reset_out       (core_reset_out),
      .pc_sp_clear_out      (pc_sp_clear_out),
      .wdt_restart_out      (wdt_restart_out),
      .lv_detect_enable_out (lv_detect_enable_out),
      .irq_out              (irq_out)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end

   // Full resets counted after release; the ceiling cuts a hang short
   always @(posedge clk_sys_in) begin
      cyc++;
      if (rstn_in && core_reset_out === 1'b1) n_core++;
      if (cyc == 8000) begin
         n_fail++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   function automatic int qticks(input logic [1:0] f);
      case (f)
         2'h0: return 8;
         2'h1: return 32;
         2'h2: return 64;
         default: return 128;
      endcase
   endfunction : qticks

   function automatic logic code_ok(input logic [7:0] c);
      return c inside {8'h55, 8'h33, 8'h99, 8'hAA};
   endfunction : code_ok

   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic settle();
      @(posedge clk_sys_in);
      #1;
   endtask : settle

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask : wr

   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      #1;
      chk(reg_rdata_out, e);
      @(posedge clk_sys_in);
   endtask : rdchk

   task automatic wait_core(input int lim);
      int n = 0;
      while (n_core == base && n < lim) begin
         settle();
         n++;
      end
      chk({7'h0, n_core > base}, 8'h01);
   endtask : wait_core

   // Short dip first, then a held dip that must qualify
   task automatic lv_run(input logic [1:0] f);
      int q;
      int n;
      q = qticks(f);
      n = 0;
      base = n_core;
      seed = xorshift(seed);
      wr(A_FILT, {seed[7:2], f});
      rdchk(A_FILT, {6'h00, f});
      supply_ok_in <= 1'b0;
      repeat (DIV * q - 8) settle();
      supply_ok_in <= 1'b1;
      repeat (12) settle();
      chk(8'(n_core - base), 8'h00);
      supply_ok_in <= 1'b0;
      while (core_reset_out !== 1'b1 && n < DIV * q + 12) begin
         settle();
         n++;
      end
      supply_ok_in <= 1'b1;
      chk({7'h0, n >= DIV * (q - 1) && n <= DIV * q + 4}, 8'h01);
      rdchk(A_CAUS, 8'h04);
      rdchk(A_CODE, code_now);
      rdchk(A_STAT, 8'h03);
      rdchk(A_IRQS, 8'h01);
      wr(A_CAUS, 8'hFC);
      rdchk(A_CAUS, 8'h04);
      wr(A_CAUS, 8'h00);
      rdchk(A_CAUS, 8'h00);
   endtask : lv_run

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk_sys_in);
      chk({6'h0, core_reset_out, wdt_restart_out}, 8'h03);
      rstn_in <= 1'b1;
      @(posedge clk_sys_in);
      rdchk(A_CODE, 8'h55);
      rdchk(A_FILT, 8'h01);
      rdchk(A_CAUS, 8'h00);
      rdchk(A_STAT, 8'h00);
      wr(A_CAUS, 8'hFF);
      rdchk(A_CAUS, 8'h00);
      wr(4'hF, 8'hFF);
      rdchk(4'hF, 8'h00);
      for (int m = 0; m < 4; m++) begin
         power_mode_in <= 2'(m);
         settle();
         settle();
         chk({7'h0, lv_detect_enable_out}, {7'h0, m < 2});
      end
      wr(A_MASK, 8'h1F);
      for (int m = 0; m < 4; m++) begin
         wr(A_STAT, 8'h00);
         power_mode_in  <= 2'(m);
         settle();
         wdt_timeout_in <= 1'b1;
         @(posedge clk_sys_in);
         wdt_timeout_in <= 1'b0;
         #1;
         chk({5'h0, wdt_restart_out, core_reset_out, pc_sp_clear_out},
             (m < 2) ? 8'h06 : 8'h05);
         rdchk(A_STAT, (m < 2) ? 8'h01 : 8'h03);
         rdchk(A_IRQS, (m < 2) ? 8'h08 : 8'h10);
      end
      power_mode_in <= 2'h0;
      base = n_core;
      for (int i = 0; i < 4; i++) begin
         wr(A_CODE, CODES[i]);
         rdchk(A_CODE, CODES[i]);
      end
      seed = xorshift(seed);
      code_now = CODES[seed[1:0]];
      wr(A_CODE, code_now);
      repeat (20) settle();
      chk(8'(n_core - base), 8'h00);
      rdchk(A_CAUS, 8'h00);
      for (int f = 0; f < 4; f++) begin
         power_mode_in <= 2'(f & 1);
         lv_run(2'(f));
      end
      wr(A_FILT, 8'h00);
      power_mode_in <= 2'h3;
      settle();
      base = n_core;
      supply_ok_in <= 1'b0;
      repeat (80) settle();
      supply_ok_in  <= 1'b1;
      power_mode_in <= 2'h0;
      chk(8'(n_core - base), 8'h00);
      do begin
         seed = xorshift(seed);
      end while (code_ok(seed[7:0]));
      base = n_core;
      wr(A_CODE, seed[7:0]);
      wait_core(60);
      settle();
      chk({7'h0, irq_out}, 8'h01);
      rdchk(A_CODE, 8'h55);
      rdchk(A_CAUS, 8'h02);
      rdchk(A_IRQS, 8'h02);
      settle();
      chk({7'h0, irq_out}, 8'h00);
      wr(A_CAUS, 8'h00);
      rdchk(A_CAUS, 8'h00);
      // Masked source must stay quiet yet still latch status
      wr(A_MASK, 8'h00);
      do begin
         seed = xorshift(seed);
      end while (seed[4:0] == 5'h0A || seed[4:0] == 5'h15);
      base = n_core;
      wdt_key_field_in <= seed[4:0];
      wait_core(60);
      wdt_key_field_in <= 5'h15;
      settle();
      chk({7'h0, irq_out}, 8'h00);
      rdchk(A_CAUS, 8'h01);
      rdchk(A_IRQS, 8'h04);
      end_of_test();
   end

endmodule : testbench
